// File: verilog/nvm_pkg.sv
// constants, register offsets and field positions for the self-programming controller
package nvm_pkg;
  // register bus geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;
  // register word offsets
  localparam logic [3:0] OFS_CONTROL    = 4'h0;
  localparam logic [3:0] OFS_ADDR_LOW   = 4'h1;
  localparam logic [3:0] OFS_ADDR_UPPER = 4'h2;
  localparam logic [3:0] OFS_KEY        = 4'h3;
  localparam logic [3:0] OFS_TBL_PAGE   = 4'h4;
  localparam logic [3:0] OFS_TBL_EA     = 4'h5;
  localparam logic [3:0] OFS_TBL_DATA   = 4'h6;
  localparam logic [3:0] OFS_TBL_CMD    = 4'h7;
  // control register fields
  localparam int BIT_START  = 15;
  localparam int BIT_WRITE_ENABLE_BIT   = 14;
  localparam int BIT_ERR    = 13;
  localparam int BIT_MULTI  = 6;
  localparam int OP_LSB     = 0;
  localparam int OP_W       = 4;
  localparam logic [3:0] OP_ROW_ERASE = 4'h1;
  localparam logic [3:0] OP_ROW_PROG  = 4'h4;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // unlock key values
  localparam logic [7:0] KEY_FIRST  = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // table command bits: bit0 write, bit1 high part, bit2 byte mode
  localparam int CMD_WRITE = 0;
  localparam int CMD_HIGH  = 1;
  localparam int CMD_BYTE  = 2;
  // row geometry
  localparam int ROW_WORDS = 32;
  localparam int ROW_BYTES = 96;
  localparam int WORD_W    = 24;
  localparam int PADDR_W   = 24;
  // operation time
  localparam int CLK_HZ       = 40_000_000;
  localparam int OP_TIME_US   = 2000;
  localparam int OP_CYCLES    = (CLK_HZ / 1_000_000) * OP_TIME_US;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ERASE = 2'b01,
    ST_PROG  = 2'b10,
    ST_DONE  = 2'b11
  } seq_state_t;
endpackage : nvm_pkg

// File: verilog/unlock_guard.sv
// unlock key detector that arms after two consecutive key writes
`timescale 1ns/100ps
module unlock_guard (
  input  wire logic       core_clk_i,   // core clock
  input  wire logic       nrst_i,       // async reset, active low
  input  wire logic       key_wr_i,     // write to key register
  input  wire logic [7:0] key_data_i,   // key byte written
  input  wire logic       start_try_i,  // start attempt consumes arming
  output logic            armed_o       // both keys seen in order
);
  import nvm_pkg::*;

  logic first_seen;  // first key just written

  // track key order; any stray key write or start attempt disarms
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      first_seen <= 1'b0;
      armed_o    <= 1'b0;
    end else if (key_wr_i) begin
      first_seen <= (key_data_i == KEY_FIRST);
      armed_o    <= first_seen && (key_data_i == KEY_SECOND);
    end else if (start_try_i) begin
      first_seen <= 1'b0;
      armed_o    <= 1'b0;
    end
  end
endmodule : unlock_guard

// File: verilog/flash_self_prog.sv
// run-time self-programming sequencer for program flash rows
// Notes on behaviour
// - erase one row of 32 instructions
// - program whole 32-word row from latches
// - low table access moves bits 15..0
// - high table access moves bits 23..16
// - table accesses support word or byte
// - address is page byte plus EA
// - operation lasts 2 ms, core stalls
// - start bit 15 launches operation
// - hardware clears start bit when done
// - latches hold 96 bytes, 64 writes
// - high latch write keeps low byte only
// - start refused unless write enable set
`timescale 1ns/100ps
module flash_self_prog #(
  parameter int OP_TIME_CYCLES = nvm_pkg::OP_CYCLES  // erase/program duration
) (
  input  wire logic                       core_clk_i,  // core clock, 40 MHz
  input  wire logic                       nrst_i,      // async reset, active low
  input  wire logic [nvm_pkg::ADDR_W-1:0] addr_i,      // register word address
  input  wire logic [nvm_pkg::DATA_W-1:0] wdata_i,     // write data
  input  wire logic                       wr_i,        // write strobe
  input  wire logic                       rd_i,        // read strobe
  output logic      [nvm_pkg::DATA_W-1:0] rdata_o,     // read data, cycle after strobe
  output logic                            stall_o,     // core stalled during operation
  output logic      [nvm_pkg::PADDR_W-1:0] flash_addr_o, // flash array address
  output logic      [nvm_pkg::WORD_W-1:0] flash_wdata_o, // word being programmed
  output logic                            flash_erase_o, // erase pulse per row
  output logic                            flash_prog_o   // program strobe per word
);
  import nvm_pkg::*;

  localparam int CNT_W = $clog2(OP_TIME_CYCLES + 1);
  localparam int IDX_W = $clog2(ROW_WORDS);

  logic [DATA_W-1:0] nvm_control_reg;    // control register
  logic [15:0]       nvm_address_low;    // row address low part
  logic [7:0]        nvm_address_upper;  // row address upper part
  logic [7:0]        table_page_reg;     // table page
  logic [15:0]       table_ea;           // effective address from working reg
  logic [15:0]       table_data;         // table data staging
  logic [WORD_W-1:0] latch_mem [ROW_WORDS];  // write latches, 96 bytes
  logic [WORD_W-1:0] flash_mem [1 << (IDX_W + 4)]; // small array model window
  logic [CNT_W-1:0]  op_cnt;             // operation timer
  logic [IDX_W-1:0]  prog_idx;           // word being programmed
  seq_state_t        state;              // sequencer state
  logic              armed;              // unlock sequence complete
  logic              start_try;          // write attempting to set start bit
  logic              start_ok;           // start accepted
  logic              key_wr;             // write to key register
  logic [PADDR_W-1:0] tbl_addr;          // formed table address
  logic [IDX_W-1:0]  lat_idx;            // latch index from table address
  logic              tbl_cmd;            // table command strobe
  logic              tbl_wr;             // table write
  logic              tbl_hi;             // high part access
  logic              tbl_byte;           // byte mode access
  logic [WORD_W-1:0] rd_word;            // word read from flash
  logic [IDX_W+3:0]  mem_idx;            // flash array index

  // program address: page byte over effective address
  function automatic logic [PADDR_W-1:0] form_addr(input logic [7:0] page, input logic [15:0] ea);
    form_addr = {page, ea};
  endfunction : form_addr

  // array index of a program word (two address units per word)
  function automatic logic [IDX_W+3:0] word_index(input logic [PADDR_W-1:0] a);
    word_index = a[IDX_W+4:1];
  endfunction : word_index

  assign tbl_addr  = form_addr(table_page_reg, table_ea);
  assign lat_idx   = tbl_addr[IDX_W:1];
  assign mem_idx   = word_index(tbl_addr);
  assign rd_word   = flash_mem[mem_idx];
  assign key_wr    = wr_i && (addr_i == OFS_KEY);
  assign tbl_cmd   = wr_i && (addr_i == OFS_TBL_CMD);
  assign tbl_wr    = wdata_i[CMD_WRITE];
  assign tbl_hi    = wdata_i[CMD_HIGH];
  assign tbl_byte  = wdata_i[CMD_BYTE];
  assign start_try = wr_i && (addr_i == OFS_CONTROL) && wdata_i[BIT_START];
  // enable must already be set; setting both at once does not start
  assign start_ok  = start_try && nvm_control_reg[BIT_WRITE_ENABLE_BIT] && armed && (state == ST_IDLE);

  unlock_guard u_guard (
    .core_clk_i  (core_clk_i),
    .nrst_i      (nrst_i),
    .key_wr_i    (key_wr),
    .key_data_i  (wdata_i[7:0]),
    .start_try_i (start_try),
    .armed_o     (armed)
  );

  // control register: software fields, start bit set by accepted start
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nvm_control_reg <= CONTROL_RESET;
    end else begin
      if (wr_i && (addr_i == OFS_CONTROL) && (state == ST_IDLE)) begin
        nvm_control_reg[BIT_WRITE_ENABLE_BIT]                 <= wdata_i[BIT_WRITE_ENABLE_BIT];
        nvm_control_reg[BIT_MULTI]                <= wdata_i[BIT_MULTI];
        nvm_control_reg[OP_LSB +: OP_W]           <= wdata_i[OP_LSB +: OP_W];
        nvm_control_reg[BIT_ERR]                  <= start_try && !start_ok;
      end
      if (start_ok) begin
        nvm_control_reg[BIT_START] <= 1'b1;
      end else if (state == ST_DONE) begin
        nvm_control_reg[BIT_START] <= 1'b0;
      end
    end
  end

  // address, page and table staging registers
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nvm_address_low   <= 16'h0000;
      nvm_address_upper <= 8'h00;
      table_page_reg    <= 8'h00;
      table_ea          <= 16'h0000;
      table_data        <= 16'h0000;
    end else if (wr_i) begin
      if (addr_i == OFS_ADDR_LOW) begin
        nvm_address_low <= wdata_i;
      end else if (addr_i == OFS_ADDR_UPPER) begin
        nvm_address_upper <= wdata_i[7:0];
      end else if (addr_i == OFS_TBL_PAGE) begin
        table_page_reg <= wdata_i[7:0];
      end else if (addr_i == OFS_TBL_EA) begin
        table_ea <= wdata_i;
      end else if (addr_i == OFS_TBL_DATA) begin
        table_data <= wdata_i;
      end else if (tbl_cmd && !tbl_wr) begin
        // table read result lands in the data register
        if (tbl_hi) begin
          table_data <= {8'h00, rd_word[23:16]};
        end else if (tbl_byte) begin
          table_data <= {8'h00, tbl_addr[0] ? rd_word[15:8] : rd_word[7:0]};
        end else begin
          table_data <= rd_word[15:0];
        end
      end
    end
  end

  // write latches loaded by table writes while idle
  always_ff @(posedge core_clk_i) begin
    if (tbl_cmd && tbl_wr && (state == ST_IDLE)) begin
      if (tbl_hi) begin
        latch_mem[lat_idx][23:16] <= table_data[7:0];
      end else if (tbl_byte && tbl_addr[0]) begin
        latch_mem[lat_idx][15:8] <= table_data[7:0];
      end else if (tbl_byte) begin
        latch_mem[lat_idx][7:0] <= table_data[7:0];
      end else begin
        latch_mem[lat_idx][15:0] <= table_data;
      end
    end
  end

  // erase/program sequencer with 2 ms stall
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state    <= ST_IDLE;
      op_cnt   <= '0;
      prog_idx <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          op_cnt   <= '0;
          prog_idx <= '0;
          if (start_ok && (wdata_i[OP_LSB +: OP_W] == OP_ROW_ERASE || nvm_control_reg[OP_LSB +: OP_W] == OP_ROW_ERASE)) begin
            state <= ST_ERASE;
          end else if (start_ok) begin
            state <= ST_PROG;
          end
        end
        ST_ERASE, ST_PROG: begin
          if (state == ST_PROG && prog_idx != IDX_W'(ROW_WORDS - 1)) begin
            prog_idx <= prog_idx + 1'b1;
          end
          if (op_cnt == CNT_W'(OP_TIME_CYCLES - 1)) begin
            state <= ST_DONE;
          end else begin
            op_cnt <= op_cnt + 1'b1;
          end
        end
        ST_DONE: begin
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // flash array update: whole row erased or programmed
  always_ff @(posedge core_clk_i) begin
    if (state == ST_ERASE && op_cnt < CNT_W'(ROW_WORDS)) begin
      flash_mem[{nvm_address_low[IDX_W+4:IDX_W+1], op_cnt[IDX_W-1:0]}] <= {WORD_W{1'b1}};
    end else if (state == ST_PROG && op_cnt < CNT_W'(ROW_WORDS)) begin
      flash_mem[{nvm_address_low[IDX_W+4:IDX_W+1], prog_idx}] <= latch_mem[prog_idx];
    end
  end

  // flash port outputs and stall, all registered
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      stall_o       <= 1'b0;
      flash_addr_o  <= '0;
      flash_wdata_o <= '0;
      flash_erase_o <= 1'b0;
      flash_prog_o  <= 1'b0;
    end else begin
      stall_o       <= start_ok || ((state == ST_ERASE || state == ST_PROG) && op_cnt != CNT_W'(OP_TIME_CYCLES - 1));
      flash_addr_o  <= {nvm_address_upper, nvm_address_low[15:IDX_W+1], prog_idx, 1'b0};
      flash_wdata_o <= latch_mem[prog_idx];
      flash_erase_o <= (state == ST_ERASE) && (op_cnt == '0);
      flash_prog_o  <= (state == ST_PROG) && (op_cnt < CNT_W'(ROW_WORDS));
    end
  end

  // register read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= '0;
    end else if (rd_i) begin
      if (addr_i == OFS_CONTROL) begin
        rdata_o <= nvm_control_reg;
      end else if (addr_i == OFS_ADDR_LOW) begin
        rdata_o <= nvm_address_low;
      end else if (addr_i == OFS_ADDR_UPPER) begin
        rdata_o <= {8'h00, nvm_address_upper};
      end else if (addr_i == OFS_TBL_PAGE) begin
        rdata_o <= {8'h00, table_page_reg};
      end else if (addr_i == OFS_TBL_EA) begin
        rdata_o <= table_ea;
      end else if (addr_i == OFS_TBL_DATA) begin
        rdata_o <= table_data;
      end else begin
        rdata_o <= '0;  // key, command and unmapped read as zero
      end
    end else begin
      rdata_o <= '0;
    end
  end
endmodule : flash_self_prog

// File: verification/flash_array_watch.sv
// far-side model of the flash array: counts erase pulses and programmed words
`timescale 1ns/100ps
module flash_array_watch (
  input  wire logic core_clk_i,     // core clock
  input  wire logic nrst_i,         // async reset, active low
  input  wire logic erase_i,        // erase pulse from the sequencer
  input  wire logic prog_i,         // program strobe from the sequencer
  output int        erase_count_o,  // row erases seen
  output int        prog_count_o    // words programmed
);
  // one row erase per pulse
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      erase_count_o <= 0;
    end else if (erase_i) begin
      erase_count_o <= erase_count_o + 1;
    end
  end
  // one word stored per strobe cycle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prog_count_o <= 0;
    end else if (prog_i) begin
      prog_count_o <= prog_count_o + 1;
    end
  end
endmodule : flash_array_watch

// File: verification/flash_self_prog_props.sv
// port assertions for the self-programming sequencer
`timescale 1ns/100ps
module flash_self_prog_props
  import nvm_pkg::*;
#(
  parameter int OP_TIME_CYCLES = 64  // operation length in cycles
) (
  input wire logic                       core_clk_i,
  input wire logic                       nrst_i,
  input wire logic [nvm_pkg::ADDR_W-1:0] addr_i,
  input wire logic [nvm_pkg::DATA_W-1:0] wdata_i,
  input wire logic                       wr_i,
  input wire logic                       rd_i,
  input wire logic [nvm_pkg::DATA_W-1:0] rdata_o,
  input wire logic                       stall_o,
  input wire logic                       flash_erase_o,
  input wire logic                       flash_prog_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!nrst_i);
  int   stall_cnt;  // cycles with stall high
  int   prog_cnt;   // cycles with program strobe high
  logic start_wr;   // control write carrying the start bit
  logic rd_ctl;     // control register read
  assign start_wr = wr_i && (addr_i == OFS_CONTROL) && wdata_i[BIT_START];
  assign rd_ctl   = rd_i && (addr_i == OFS_CONTROL);
  // stall length counter, cleared while idle
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) stall_cnt <= 0;
    else stall_cnt <= stall_o ? stall_cnt + 1 : 0;
  end
  // program strobe length counter
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) prog_cnt <= 0;
    else prog_cnt <= flash_prog_o ? prog_cnt + 1 : 0;
  end
  property p_start_cause; $rose(stall_o) |-> $past(start_wr); endproperty
  a_start_cause: assert property (p_start_cause) else $error("stall without start write");
  property p_stall_hold; $rose(stall_o) |-> stall_o [*8]; endproperty
  a_stall_hold: assert property (p_stall_hold) else $error("stall dropped early");
  property p_stall_len;
    $fell(stall_o) |-> stall_cnt >= OP_TIME_CYCLES - 1 && stall_cnt <= OP_TIME_CYCLES + 2;
  endproperty
  a_stall_len: assert property (p_stall_len) else $error("operation length wrong");
  property p_erase_pulse; flash_erase_o |=> !flash_erase_o; endproperty
  a_erase_pulse: assert property (p_erase_pulse) else $error("erase pulse too long");
  property p_prog_len; $fell(flash_prog_o) |-> prog_cnt == ROW_WORDS; endproperty
  a_prog_len: assert property (p_prog_len) else $error("row program count wrong");
  property p_op_in_stall; (flash_erase_o || flash_prog_o) |-> stall_o; endproperty
  a_op_in_stall: assert property (p_op_in_stall) else $error("flash busy without stall");
  property p_op_follows; $rose(stall_o) |-> ##[0:4] (flash_erase_o || flash_prog_o); endproperty
  a_op_follows: assert property (p_op_follows) else $error("no flash action after start");
  property p_start_clear; rd_ctl && !stall_o && !$past(stall_o) |=> !rdata_o[BIT_START]; endproperty
  a_start_clear: assert property (p_start_clear) else $error("start bit left set");
  property p_busy_bit; rd_ctl && stall_o |=> rdata_o[BIT_START]; endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("start bit clear while busy");
  c_erase: cover property (flash_erase_o);
  c_prog: cover property ($fell(flash_prog_o));
  c_refused: cover property (start_wr ##1 !stall_o);
endmodule : flash_self_prog_props
bind flash_self_prog flash_self_prog_props #(.OP_TIME_CYCLES(OP_TIME_CYCLES)) u_props (
  .core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .stall_o(stall_o), .flash_erase_o(flash_erase_o), .flash_prog_o(flash_prog_o));

// File: verification/tb_flash_self_prog.sv
// self-checking bench for the self-programming sequencer
`timescale 1ns/100ps
module tb_flash_self_prog;
  import nvm_pkg::*;
  localparam int OPT = 64;  // shortened operation time
  typedef struct packed {logic [7:0] k1; logic [7:0] k2; logic [15:0] pre; logic [15:0] go; logic ok;} case_t;
  logic        core_clk_i = 1'b0;
  logic        nrst_i     = 1'b0;
  logic [3:0]  addr_i     = 4'h0;
  logic [15:0] wdata_i    = 16'h0000;
  logic        wr_i       = 1'b0;
  logic        rd_i       = 1'b0;
  logic [15:0] rdata_o, rv;
  logic [23:0] flash_addr_o, flash_wdata_o;
  logic        stall_o, flash_erase_o, flash_prog_o;
  int          erase_count, prog_count, mismatches = 0, n_checks = 0;
  case_t       rows [5];  // unlock and enable combinations, last one starts
  int          picks [3] = '{0, 17, 31};  // row words read back after programming
  always #12.5 core_clk_i = ~core_clk_i;
  flash_self_prog #(.OP_TIME_CYCLES(OPT)) dut_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .stall_o(stall_o),
    .flash_addr_o(flash_addr_o), .flash_wdata_o(flash_wdata_o), .flash_erase_o(flash_erase_o),
    .flash_prog_o(flash_prog_o));
  flash_array_watch far_u (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .erase_i(flash_erase_o),
    .prog_i(flash_prog_o), .erase_count_o(erase_count), .prog_count_o(prog_count));
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // compare seen against expected
  task check(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one-cycle register write, then a quiet cycle
  task wr(input logic [3:0] a, input logic [15:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    @(posedge core_clk_i);
  endtask : wr
  // one-cycle read, data taken in the following cycle
  task rd(input logic [3:0] a);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    @(negedge core_clk_i);
    rv = rdata_o;
    @(posedge core_clk_i);
  endtask : rd
  // key pair then the start write
  task launch(input logic [7:0] k1, input logic [7:0] k2, input logic [15:0] go);
    wr(OFS_KEY, {8'h00, k1});
    wr(OFS_KEY, {8'h00, k2});
    wr(OFS_CONTROL, go);
  endtask : launch
  // bounded wait for the operation to end
  task wait_idle;
    int n;
    n = 0;
    while (stall_o !== 1'b0 && n < 4 * OPT) begin
      @(posedge core_clk_i);
      n++;
    end
    if (n >= 4 * OPT) begin
      mismatches++;
      $display("ERROR %0t: operation hung", $time);
      test_done();
    end
  endtask : wait_idle
  initial begin
    rows = '{'{8'h55, 8'hAA, 16'h0041, 16'h8041, 1'b0}, '{8'h55, 8'hAA, 16'h0041, 16'hC041, 1'b0},
             '{8'hAA, 8'h55, 16'h4041, 16'hC041, 1'b0}, '{8'h55, 8'h00, 16'h4041, 16'hC041, 1'b0},
             '{8'h55, 8'hAA, 16'h4041, 16'hC041, 1'b1}};
    repeat (20) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    rd(OFS_CONTROL);
    check(24'(rv), 24'(CONTROL_RESET));
    check(24'(stall_o), 24'h0);
    $display("test reset done");
    wr(OFS_ADDR_LOW, 16'h0040);
    wr(OFS_ADDR_UPPER, 16'h0000);
    foreach (rows[i]) begin
      wr(OFS_CONTROL, rows[i].pre);
      launch(rows[i].k1, rows[i].k2, rows[i].go);
      @(negedge core_clk_i);
      check(24'(stall_o), 24'(rows[i].ok));
      @(posedge core_clk_i);
      rd(OFS_CONTROL);
      if (rows[i].ok) begin
        check(24'(rv[BIT_START]), 24'h1);
        wait_idle();
        rd(OFS_CONTROL);
        check(24'(rv[BIT_START]), 24'h0);
        check(24'(erase_count), 24'h1);
      end else begin
        check(24'(rv[BIT_ERR]), 24'h1);
      end
    end
    wr(OFS_CONTROL, 16'hC041);
    @(negedge core_clk_i);
    check(24'(stall_o), 24'h0);
    @(posedge core_clk_i);
    $display("test unlock and erase done");
    wr(OFS_TBL_PAGE, 16'h0000);
    for (int i = 0; i < ROW_WORDS; i++) begin
      wr(OFS_TBL_EA, 16'(16'h0040 + 2 * i));
      wr(OFS_TBL_DATA, 16'(16'h1200 + i));
      wr(OFS_TBL_CMD, 16'h0001);
      wr(OFS_TBL_DATA, 16'(16'hAB80 + i));
      wr(OFS_TBL_CMD, 16'h0003);
    end
    wr(OFS_CONTROL, 16'h4044);
    launch(8'h55, 8'hAA, 16'hC044);
    @(negedge core_clk_i);
    check(24'(stall_o), 24'h1);
    @(posedge core_clk_i);
    wait_idle();
    check(24'(prog_count), 24'(ROW_WORDS));
    foreach (picks[j]) begin
      wr(OFS_TBL_EA, 16'(16'h0040 + 2 * picks[j]));
      wr(OFS_TBL_CMD, 16'h0000);
      rd(OFS_TBL_DATA);
      check(24'(rv), 24'(16'h1200 + picks[j]));
      wr(OFS_TBL_CMD, 16'h0002);
      rd(OFS_TBL_DATA);
      check(24'(rv), 24'(8'h80 + picks[j]));
    end
    // idle flash port rests on the first word of the programmed row
    check(flash_addr_o, 24'h00_0040);
    check(flash_wdata_o, 24'h80_1200);
    $display("test row program done");
    test_done();
  end
endmodule : tb_flash_self_prog
